// ==== hw/gtu_defines.svh ====
// register offsets, field positions, reset values and timing counts of the guard timer unit
`ifndef GTU_DEFINES_SVH
`define GTU_DEFINES_SVH

`define GTU_OFF_RELOAD_HIGH   16'hF4C0
`define GTU_OFF_RELOAD_LOW    16'hF4C2
`define GTU_OFF_COUNT_HIGH    16'hF4C4
`define GTU_OFF_COUNT_LOW     16'hF4C6
`define GTU_OFF_UNLOCK_CLEAR  16'hF4C8
`define GTU_OFF_MODE_STATUS   16'hF4CA

`define GTU_BIT_GUARD_EN      7
`define GTU_BIT_MONITOR_EN    1
`define GTU_BIT_CLOCK_DIS     0

`define GTU_RELOAD_RESET      32'h0000FFFF
`define GTU_UNLOCK_FIRST      16'hF01E
`define GTU_UNLOCK_SECOND     16'h0FE1

`define GTU_PULSE_CYCLES      4'h8

`endif

// ==== hw/gtu_guard_timer_unit.sv ====
// guard timer unit: timer, software watchdog and bus-cycle monitor behind an apb slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "gtu_defines.svh"

// Notes on behaviour
// - holds 32-bit reload, 32-bit down-counter, eight-state pulse counter, count and status.
// - after reset counts down as timer, timing out after 64K cycles.
// - only one of timer, watchdog or monitor mode is active.
// - a running down-counter decrements by one every clock.
// - reaching zero drives timeout output high for exactly eight clocks.
// - an inverted copy of the timeout output feeds the slave interrupt line.
// - reload on unlock in watchdog, strobe in monitor, zero in every mode.
// - idle stops the counter only in watchdog mode.
// - powerdown stops the unit in every mode.
// - in monitor mode strobe reloads and starts, cycle done stops.
// - each cycle-done pairs with its own strobe, also two strobes pipelined.
// - unlock sequence at clear port enables watchdog and reloads counter.
// - count registers show the live counter; reloads load it from reload registers.
// - after an unlock, reload register writes are ignored until reset.
// - unlock sets enabled flag, clears monitor and clock-disable, locks status writes.
// - before unlock, monitor bit selects monitor mode, clock-disable stops the unit.
// - unlock is 16-bit F01E then 0FE1 back to back; anything else rejected.
// - reload from zero happens in the clock cycle right after the zero count.
// - status bit 7 enabled flag, bit 1 monitor enable, bit 0 clock disable.
// - reload register and down-counter reset to 0000FFFF.
module gtu_guard_timer_unit #(
  parameter int unsigned       CNT_W      = 32,
  parameter logic [31:0]       RELOAD_RST = `GTU_RELOAD_RESET
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [15:0]     paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire gtu_pkg::gtu_sys_in_t sys_in,
  output logic                 timeout_out,
  output logic                 slave_irq_line
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  function automatic logic gtu_hit(input logic [15:0] a, input logic [15:0] off);
    gtu_hit = (a == off);
  endfunction

  // a legal 16-bit word access uses the low two byte lanes only
  function automatic logic gtu_word(input logic [3:0] s);
    gtu_word = (s == 4'h3);
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [CNT_W-1:0]  reload_r;
  logic [CNT_W-1:0]  count_r;
  logic              at_zero_r;
  logic [3:0]        pulse_cnt_r;
  logic              timeout_r;
  logic              irq_n_r;
  logic              guard_en_r;
  logic              monitor_en_r;
  logic              clock_dis_r;
  logic              mon_run_r;
  logic [1:0]        pending_r;
  gtu_pkg::gtu_unlock_t unl_state_r;
  logic              unlock_pulse;
  logic              acc;
  logic              wr;
  logic              addr_ok;
  gtu_pkg::gtu_mode_t mode;
  logic              running;
  logic              strobe_hit;
  logic              done_hit;
  logic [31:0]       rdata_nxt;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // a write lands only on the edge that completes the transfer, so a stretched access cannot act twice
  assign acc     = psel && penable && pready;
  assign wr      = acc && pwrite;
  assign addr_ok = gtu_hit(paddr, `GTU_OFF_RELOAD_HIGH) || gtu_hit(paddr, `GTU_OFF_RELOAD_LOW)
                || gtu_hit(paddr, `GTU_OFF_COUNT_HIGH) || gtu_hit(paddr, `GTU_OFF_COUNT_LOW)
                || gtu_hit(paddr, `GTU_OFF_UNLOCK_CLEAR) || gtu_hit(paddr, `GTU_OFF_MODE_STATUS);

  // ---------------------------------------------------------------
  // mode selection
  // ---------------------------------------------------------------
  always_comb begin
    if (guard_en_r) begin
      mode = gtu_pkg::GTU_MODE_WATCHDOG;
    end else if (monitor_en_r) begin
      mode = gtu_pkg::GTU_MODE_MONITOR;
    end else begin
      mode = gtu_pkg::GTU_MODE_TIMER;
    end
  end

  // external strobes arrive from logic on pclk, so they are used without synchronisers
  assign strobe_hit = (mode == gtu_pkg::GTU_MODE_MONITOR) && sys_in.addr_strobe;
  assign done_hit   = (mode == gtu_pkg::GTU_MODE_MONITOR) && sys_in.cycle_done;

  always_comb begin
    running = !sys_in.powerdown && !clock_dis_r;
    case (mode)
      gtu_pkg::GTU_MODE_WATCHDOG: running = running && !sys_in.idle;
      gtu_pkg::GTU_MODE_MONITOR:  running = running && mon_run_r;
      gtu_pkg::GTU_MODE_TIMER:    running = running;
      default:                    running = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // unlock sequence decoder
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl_state_r <= gtu_pkg::GTU_UNL_IDLE;
    end else if (wr) begin
      // any bus write in between breaks the pair, so the two words must be consecutive
      case (unl_state_r)
        gtu_pkg::GTU_UNL_IDLE: begin
          if (gtu_hit(paddr, `GTU_OFF_UNLOCK_CLEAR) && gtu_word(pstrb)
              && pwdata[15:0] == `GTU_UNLOCK_FIRST) begin
            unl_state_r <= gtu_pkg::GTU_UNL_ARMED;
          end
        end
        gtu_pkg::GTU_UNL_ARMED: begin
          unl_state_r <= gtu_pkg::GTU_UNL_IDLE;
          if (gtu_hit(paddr, `GTU_OFF_UNLOCK_CLEAR) && gtu_word(pstrb)
              && pwdata[15:0] == `GTU_UNLOCK_FIRST) begin
            unl_state_r <= gtu_pkg::GTU_UNL_ARMED;
          end
        end
        default: unl_state_r <= gtu_pkg::GTU_UNL_IDLE;
      endcase
    end
  end

  assign unlock_pulse = wr && (unl_state_r == gtu_pkg::GTU_UNL_ARMED)
                     && gtu_hit(paddr, `GTU_OFF_UNLOCK_CLEAR) && gtu_word(pstrb)
                     && pwdata[15:0] == `GTU_UNLOCK_SECOND;

  // ---------------------------------------------------------------
  // status register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_en_r   <= 1'b0;
      monitor_en_r <= 1'b0;
      clock_dis_r  <= 1'b0;
    end else if (unlock_pulse) begin
      guard_en_r   <= 1'b1;
      monitor_en_r <= 1'b0;
      clock_dis_r  <= 1'b0;
    end else if (wr && !guard_en_r && gtu_hit(paddr, `GTU_OFF_MODE_STATUS) && pstrb[0]) begin
      monitor_en_r <= pwdata[`GTU_BIT_MONITOR_EN];
      clock_dis_r  <= pwdata[`GTU_BIT_CLOCK_DIS];
    end
  end

  // ---------------------------------------------------------------
  // reload register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_r <= CNT_W'(RELOAD_RST);
    end else if (wr && !guard_en_r && gtu_word(pstrb)) begin
      if (gtu_hit(paddr, `GTU_OFF_RELOAD_HIGH)) begin
        reload_r[CNT_W-1:16] <= pwdata[CNT_W-17:0];
      end else if (gtu_hit(paddr, `GTU_OFF_RELOAD_LOW)) begin
        reload_r[15:0] <= pwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // bus monitor pairing
  // ---------------------------------------------------------------
  // pending counts strobes without their done; the counter stops only when the last one completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_r <= 2'h0;
      mon_run_r <= 1'b0;
    end else if (mode != gtu_pkg::GTU_MODE_MONITOR) begin
      pending_r <= 2'h0;
      mon_run_r <= 1'b0;
    end else begin
      case ({strobe_hit, done_hit})
        2'b10: begin
          if (pending_r != 2'h3) begin
            pending_r <= pending_r + 2'h1;
          end
          mon_run_r <= 1'b1;
        end
        2'b01: begin
          if (pending_r != 2'h0) begin
            pending_r <= pending_r - 2'h1;
          end
          mon_run_r <= (pending_r > 2'h1);
        end
        2'b11: mon_run_r <= 1'b1;
        default: mon_run_r <= mon_run_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // down-counter
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r   <= CNT_W'(RELOAD_RST);
      at_zero_r <= 1'b0;
    end else begin
      at_zero_r <= 1'b0;
      if (unlock_pulse || strobe_hit) begin
        count_r <= reload_r;
      end else if (at_zero_r) begin
        count_r <= reload_r;
      end else if (running) begin
        count_r <= count_r - CNT_W'(1);
        // zero is held for one cycle, then reloaded
        at_zero_r <= (count_r == CNT_W'(1));
      end
    end
  end

  // ---------------------------------------------------------------
  // timeout pulse stretcher
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_r <= 4'h0;
      timeout_r   <= 1'b0;
      irq_n_r     <= 1'b1;
    end else if (at_zero_r) begin
      pulse_cnt_r <= `GTU_PULSE_CYCLES - 4'h1;
      timeout_r   <= 1'b1;
      irq_n_r     <= 1'b0;
    end else if (pulse_cnt_r != 4'h0) begin
      pulse_cnt_r <= pulse_cnt_r - 4'h1;
    end else begin
      timeout_r <= 1'b0;
      irq_n_r   <= 1'b1;
    end
  end

  assign timeout_out    = timeout_r;
  assign slave_irq_line = irq_n_r;

  // ---------------------------------------------------------------
  // read data and response
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0;
    if (gtu_hit(paddr, `GTU_OFF_RELOAD_HIGH)) begin
      rdata_nxt[15:0] = reload_r[31:16];
    end else if (gtu_hit(paddr, `GTU_OFF_RELOAD_LOW)) begin
      rdata_nxt[15:0] = reload_r[15:0];
    end else if (gtu_hit(paddr, `GTU_OFF_COUNT_HIGH)) begin
      rdata_nxt[15:0] = count_r[31:16];
    end else if (gtu_hit(paddr, `GTU_OFF_COUNT_LOW)) begin
      rdata_nxt[15:0] = count_r[15:0];
    end else if (gtu_hit(paddr, `GTU_OFF_MODE_STATUS)) begin
      rdata_nxt[`GTU_BIT_GUARD_EN]   = guard_en_r;
      rdata_nxt[`GTU_BIT_MONITOR_EN] = monitor_en_r;
      rdata_nxt[`GTU_BIT_CLOCK_DIS]  = clock_dis_r;
    end
  end

  // no wait state: pready is registered and rises on the edge that ends the setup cycle, so the first access cycle completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= !addr_ok;
      prdata  <= pwrite ? 32'h0 : rdata_nxt;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
  end

endmodule

// ==== hw/gtu_pkg.sv ====
// types shared by the guard timer unit
package gtu_pkg;

  typedef enum logic [1:0] {
    GTU_MODE_TIMER,
    GTU_MODE_WATCHDOG,
    GTU_MODE_MONITOR
  } gtu_mode_t;

  typedef enum logic [1:0] {
    GTU_UNL_IDLE,
    GTU_UNL_ARMED
  } gtu_unlock_t;

  typedef struct packed {
    logic addr_strobe;
    logic cycle_done;
    logic idle;
    logic powerdown;
  } gtu_sys_in_t;

endpackage

// ==== tb/gtu_biu_model.sv ====
// bus interface unit model: address strobes and cycle-done pulses
`timescale 1ns/1ps
module gtu_biu_model (
  input  wire logic pclk,
  output logic      addr_strobe,
  output logic      cycle_done
);
  initial begin
    addr_strobe = 1'b0;
    cycle_done  = 1'b0;
  end
  // -----------------------------------------
  // strobes go out before their dones, up to two outstanding when pipelined
  // -----------------------------------------
  task automatic bus_cycles(input int strobes, input int lat, input int dones);
    repeat (strobes) begin
      @(posedge pclk);
      addr_strobe <= 1'b1;
    end
    @(posedge pclk);
    addr_strobe <= 1'b0;
    repeat (lat) @(posedge pclk);
    // a slow or missing done is how a hung bus cycle looks from here
    repeat (dones) begin
      @(posedge pclk);
      cycle_done <= 1'b1;
    end
    @(posedge pclk);
    cycle_done <= 1'b0;
  endtask
endmodule

// ==== tb/gtu_guard_timer_unit_bench.sv ====
// self-checking bench of the guard timer unit
`timescale 1ns/1ps
`include "gtu_defines.svh"
module gtu_guard_timer_unit_bench;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic                 st, dn, idle, pd, timeout_out, slave_irq_line, to_q;
  logic [15:0]          paddr;
  logic [31:0]          pwdata, prdata, q, q1;
  logic [3:0]           pstrb;
  gtu_pkg::gtu_sys_in_t sys_in;
  int                   mismatches, samples_checked, seed, cyc, rises, last_rise, prev_rise, n, r;
  assign sys_in = {st, dn, idle, pd};
  gtu_guard_timer_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_in(sys_in), .timeout_out(timeout_out), .slave_irq_line(slave_irq_line));
  gtu_biu_model i_biu (.pclk(pclk), .addr_strobe(st), .cycle_done(dn));
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (timeout_out === 1'b1 && to_q === 1'b0) begin
      prev_rise = last_rise;
      last_rise = cyc;
      rises++;
    end
    to_q = timeout_out;
  end
  // ----------------
  // helpers
  // ----------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic int exp_period(input int rl, input int held);
    return rl + 1 + held;
  endfunction
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, wr, a, d, 4'h3};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) mismatches++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rises(input int k);
    int lim, r0;
    lim = 0;
    r0 = rises;
    while (rises < r0 + k && lim < 5000) begin
      @(posedge pclk);
      lim++;
    end
    if (rises < r0 + k) mismatches++;
  endtask
  task automatic unlock();
    apb(1'b1, `GTU_OFF_UNLOCK_CLEAR, `GTU_UNLOCK_FIRST);
    apb(1'b1, `GTU_OFF_UNLOCK_CLEAR, `GTU_UNLOCK_SECOND);
  endtask
  // ----------------
  // tests
  // ----------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb, idle, pd, to_q} = '0;
    {mismatches, samples_checked, cyc, rises, last_rise, prev_rise} = '0;
    seed = 32'h3b7e;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `GTU_OFF_RELOAD_LOW, 0);  check(q, 32'h0000FFFF);
    apb(1'b0, `GTU_OFF_RELOAD_HIGH, 0); check(q, 32'h0);
    apb(1'b0, `GTU_OFF_COUNT_HIGH, 0);  check(q, 32'h0);
    apb(1'b0, `GTU_OFF_MODE_STATUS, 0); check(q, 32'h0);
    apb(1'b0, 16'hF4CC, 0);             check(err, 1'b1);
    apb(1'b0, `GTU_OFF_COUNT_LOW, 0);
    q1 = q;
    apb(1'b0, `GTU_OFF_COUNT_LOW, 0);   check(q1 - q, 32'h3);
    $display("test reset and count done");
    // short reload keeps every period within a few hundred cycles
    n = 20 + ($unsigned($random(seed)) % 64);
    apb(1'b1, `GTU_OFF_RELOAD_HIGH, 0);
    apb(1'b1, `GTU_OFF_RELOAD_LOW, n);
    apb(1'b1, `GTU_OFF_MODE_STATUS, 32'h2);
    apb(1'b0, `GTU_OFF_MODE_STATUS, 0); check(q, 32'h2);
    i_biu.bus_cycles(1, 3, 1);
    apb(1'b0, `GTU_OFF_COUNT_LOW, 0);
    q1 = q;
    apb(1'b0, `GTU_OFF_COUNT_LOW, 0);   check(q, q1);
    check(q < n, 1'b1);
    r = rises;
    repeat (3 * n) @(posedge pclk);
    check(rises - r, 32'h0);
    i_biu.bus_cycles(2, 3, 1);
    wait_rises(1);                      check(rises - r, 32'h1);
    $display("test monitor mode done");
    apb(1'b1, `GTU_OFF_MODE_STATUS, 32'h0);
    idle <= 1'b1;
    wait_rises(2);                      check(last_rise - prev_rise, exp_period(n, 0));
    check(slave_irq_line, 1'b0);
    idle <= 1'b0;
    wait_rises(1);
    repeat (3) @(posedge pclk);
    pd <= 1'b1;
    repeat (10) @(posedge pclk);
    pd <= 1'b0;
    wait_rises(1);                      check(last_rise - prev_rise, exp_period(n, 10));
    apb(1'b1, `GTU_OFF_MODE_STATUS, 32'h1);
    apb(1'b0, `GTU_OFF_MODE_STATUS, 0); check(q, 32'h1);
    r = rises;
    repeat (3 * n) @(posedge pclk);
    check(rises - r, 32'h0);
    $display("test timer mode done");
    apb(1'b1, `GTU_OFF_MODE_STATUS, 32'h2);
    apb(1'b1, `GTU_OFF_UNLOCK_CLEAR, `GTU_UNLOCK_FIRST);
    apb(1'b1, `GTU_OFF_UNLOCK_CLEAR, 32'h1234);
    apb(1'b0, `GTU_OFF_MODE_STATUS, 0); check(q, 32'h2);
    unlock();
    apb(1'b0, `GTU_OFF_MODE_STATUS, 0); check(q, 32'h80);
    apb(1'b1, `GTU_OFF_RELOAD_LOW, 5);
    apb(1'b0, `GTU_OFF_RELOAD_LOW, 0);  check(q, n);
    apb(1'b1, `GTU_OFF_MODE_STATUS, 32'h3);
    apb(1'b0, `GTU_OFF_MODE_STATUS, 0); check(q, 32'h80);
    unlock();
    idle <= 1'b1;
    r = rises;
    repeat (3 * n) @(posedge pclk);
    check(rises - r, 32'h0);
    idle <= 1'b0;
    repeat (6) begin
      unlock();
      repeat ($unsigned($random(seed)) % (n / 2)) @(posedge pclk);
    end
    check(rises - r, 32'h0);
    wait_rises(1);                      check(rises - r, 32'h1);
    $display("test watchdog mode done");
    report_and_stop();
  end
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
endmodule

// ==== tb/gtu_guard_timer_unit_chk.sv ====
// port-level checker for the guard timer unit
`timescale 1ns/1ps
`include "gtu_defines.svh"
module gtu_guard_timer_unit_chk (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [15:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire gtu_pkg::gtu_sys_in_t sys_in,
  input wire logic                 timeout_out,
  input wire logic                 slave_irq_line
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------
  // sequences
  // ----------------
  sequence s_setup;  psel && !penable; endsequence
  sequence s_read;   psel && penable && pready && !pwrite; endsequence
  sequence s_pulse;  timeout_out [*8] ##1 !timeout_out; endsequence
  a_pulse_eight: assert property ($rose(timeout_out) |-> s_pulse)
    else $error("timeout pulse length wrong");
  a_irq_inverse: assert property (slave_irq_line == !timeout_out)
    else $error("interrupt line not inverse of timeout");
  a_ready_answer: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_err: assert property (psel && penable && pready && !(paddr inside {16'hF4C0, 16'hF4C2, 16'hF4C4,
    16'hF4C6, 16'hF4C8, 16'hF4CA}) |-> pslverr) else $error("unmapped access without error");
  a_status_upper: assert property (s_read and paddr == `GTU_OFF_MODE_STATUS |-> prdata[31:8] == 24'h0)
    else $error("status upper bits not zero");
  a_count_upper: assert property (s_read and paddr inside {16'hF4C4, 16'hF4C6} |-> prdata[31:16] == 16'h0)
    else $error("count upper bits not zero");
  a_powerdown_hold: assert property (sys_in.powerdown && $past(sys_in.powerdown) && $past(sys_in.powerdown, 2)
    |-> !$rose(timeout_out)) else $error("timeout during powerdown");
endmodule
bind gtu_guard_timer_unit gtu_guard_timer_unit_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sys_in(sys_in), .timeout_out(timeout_out), .slave_irq_line(slave_irq_line));
